/* File: hdl/cctt_pkg.sv */
// package: register map, field layout, timing and state types of the capture/compare timer
package cctt_pkg;

	// ------------------------------------------------------------
	// register word indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CNT = 6'h00;
	localparam logic [5:0] IDX_GRA = 6'h01;
	localparam logic [5:0] IDX_GRB = 6'h02;
	localparam logic [5:0] IDX_GRC = 6'h03;
	localparam logic [5:0] IDX_GRD = 6'h04;
	localparam logic [5:0] IDX_MODE = 6'h05;
	localparam logic [5:0] IDX_TCTL = 6'h06;
	localparam logic [5:0] IDX_IOC_LO = 6'h07;
	localparam logic [5:0] IDX_IOC_HI = 6'h08;
	localparam logic [5:0] IDX_STATUS = 6'h09;
	localparam logic [5:0] IDX_IEN = 6'h0a;

	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int MODE_CTS = 0;
	localparam int MODE_BUFA = 1;
	localparam int MODE_BUFB = 2;
	localparam int TCTL_CLEAR_ON_MATCH_ENABLE = 3;
	localparam int TCTL_INIT_LSB = 4;
	localparam int IOC_CAP = 3;
	localparam int ST_OVF = 4;
	localparam int NCH = 4;

	// clock source select, timer_control_reg[2:0]
	localparam logic [2:0] CSEL_DIV1 = 3'h0;
	localparam logic [2:0] CSEL_DIV2 = 3'h1;
	localparam logic [2:0] CSEL_DIV8 = 3'h2;
	localparam logic [2:0] CSEL_DIV32 = 3'h3;
	localparam int CSEL_EXT = 2;
	localparam int PRESC_DIV2 = 0;
	localparam int PRESC_DIV8 = 2;
	localparam int PRESC_DIV32 = 4;

	// compare output action / capture edge codes, io control nibble [1:0]
	localparam logic [1:0] OUT_NONE = 2'h0;
	localparam logic [1:0] OUT_LOW = 2'h1;
	localparam logic [1:0] OUT_HIGH = 2'h2;
	localparam logic [1:0] OUT_TOGGLE = 2'h3;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;

	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] GR_RESET = 16'hffff;

	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] main_up_counter;
		logic [NCH-1:0][15:0] gr;
		logic [2:0] mode;
		logic [7:0] timer_control_reg;
		logic [7:0] io_control_low;
		logic [7:0] io_control_high;
		logic [4:0] flags;
		logic [4:0] armed;
		logic [4:0] ien;
		logic [7:0] presc;
		logic src_prev;
		logic [NCH-1:0] pin;
		logic [NCH-1:0] oe;
		logic irq;
		logic ack;
		logic [31:0] dat;
	} cctt_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
	} cctt_samp_t;

endpackage

/* File: hdl/cctt_sampler.sv */
// two-stage input synchroniser with edge detection for one pin
`timescale 1ns/1ps
`default_nettype none

module cctt_sampler (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sig_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);

	cctt_pkg::cctt_samp_t st_r;
	cctt_pkg::cctt_samp_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = sig_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.prev = st_r.s2;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// edges only from the second stage onward
	assign level_o = st_r.s2;
	assign rise_o = st_r.s2 & ~st_r.prev;
	assign fall_o = ~st_r.s2 & st_r.prev;

	property p_rise_seen;
		@(posedge clk_i) disable iff (rst_i)
		($rose(sig_i) ##1 sig_i) |=> rise_o;
	endproperty
	a_rise_seen: assert property (p_rise_seen) else $error("held rising input not detected");

endmodule

`default_nettype wire

/* File: hdl/cctt_timer.sv */
// 16-bit capture/compare timer with four general registers on a classic wishbone slave
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - compare match when counter leaves matching value
// - match drives pin low, high or toggle
// - capture on rising, falling or both edges
// - clear on match A gives period N+1
// - compare match sets channel match flag
// - capture event sets channel match flag
// - flag clears after read-one then write-zero
// - counter clear beats software counter write
// - software counter write beats count-up
// - source switch low-to-high counts as edge
// - initial level drives pin until match
// - control write beats match pin change
// - counter wrap sets overflow, optional interrupt
// - clear on match A only when enabled
// - buffered capture moves A into C
// - buffered compare reloads A from C
module cctt_timer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_clk_i,
	input wire logic [3:0] chan_pin_i,
	output logic [3:0] chan_pin_o,
	output logic [3:0] chan_pin_oe_o,
	output logic irq_o
);
	default clocking cb_sys @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] ch_cfg(input logic [7:0] lo, input logic [7:0] hi, input int ch);
		logic [15:0] all;
		all = {hi, lo};
		ch_cfg = all[ch*4 +: 4];
	endfunction
	function automatic logic edge_hit(input logic [3:0] cfg, input logic rise, input logic fall);
		if (cfg[1]) begin
			edge_hit = rise | fall;
		end else if (cfg[1:0] == cctt_pkg::EDGE_FALL) begin
			edge_hit = fall;
		end else begin
			edge_hit = rise;
		end
	endfunction
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
		merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] sel);
		merge8 = sel[0] ? d[7:0] : old;
	endfunction

	// ------------------------------------------------------------
	// input sampling
	// ------------------------------------------------------------
	logic [4:0] raw_in;
	logic [4:0] lvl_s;
	logic [4:0] rise_s;
	logic [4:0] fall_s;
	assign raw_in = {ext_clk_i, chan_pin_i};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_samp
			cctt_sampler u_samp (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.sig_i(raw_in[gi]),
				.level_o(lvl_s[gi]),
				.rise_o(rise_s[gi]),
				.fall_o(fall_s[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	cctt_pkg::cctt_state_t st_r;
	cctt_pkg::cctt_state_t st_nxt;

	logic [5:0] idx;
	logic acc;
	logic wr;
	logic cnt_wr;
	logic tctl_wr;
	logic st_wr;
	logic src_lvl;
	logic tick;
	logic clr_ev;
	logic [3:0] cfg [cctt_pkg::NCH];
	logic [3:0] match_ev;
	logic [3:0] cap_ev;
	logic [3:0] idle_ch;
	logic [31:0] rd_mux;

	assign idx = wb_adr_i[7:2];
	assign acc = wb_cyc_i & wb_stb_i & st_r.ack;
	assign wr = acc & wb_we_i;
	assign cnt_wr = wr && idx == cctt_pkg::IDX_CNT;
	assign tctl_wr = wr && idx == cctt_pkg::IDX_TCTL;
	assign st_wr = wr && idx == cctt_pkg::IDX_STATUS;

	// ------------------------------------------------------------
	// count source: every clock with CSEL_DIV1, else rising edge of the selected level
	// ------------------------------------------------------------
	always_comb begin
		unique case (st_r.timer_control_reg[2:0])
			cctt_pkg::CSEL_DIV1: src_lvl = 1'b1;
			cctt_pkg::CSEL_DIV2: src_lvl = st_r.presc[cctt_pkg::PRESC_DIV2];
			cctt_pkg::CSEL_DIV8: src_lvl = st_r.presc[cctt_pkg::PRESC_DIV8];
			cctt_pkg::CSEL_DIV32: src_lvl = st_r.presc[cctt_pkg::PRESC_DIV32];
			default: src_lvl = lvl_s[cctt_pkg::NCH];
		endcase
	end

	// switching from a low source to a high one is seen as an edge
	assign tick = st_r.mode[cctt_pkg::MODE_CTS] &&
		(st_r.timer_control_reg[2:0] == cctt_pkg::CSEL_DIV1 || (src_lvl && !st_r.src_prev));

	// ------------------------------------------------------------
	// channel events
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < cctt_pkg::NCH; i++) begin
			cfg[i] = ch_cfg(st_r.io_control_low, st_r.io_control_high, i);
			// match only on the last state of equality, at the count clock
			match_ev[i] = tick && !cfg[i][cctt_pkg::IOC_CAP] && !idle_ch[i] &&
				st_r.main_up_counter == st_r.gr[i];
			cap_ev[i] = cfg[i][cctt_pkg::IOC_CAP] && !idle_ch[i] &&
				edge_hit(cfg[i], rise_s[i], fall_s[i]);
		end
	end

	assign clr_ev = match_ev[0] && st_r.timer_control_reg[cctt_pkg::TCTL_CLEAR_ON_MATCH_ENABLE];
	// c and d act only as buffers while buffering is on
	assign idle_ch = {st_r.mode[cctt_pkg::MODE_BUFB], st_r.mode[cctt_pkg::MODE_BUFA], 2'b00};

	always_comb begin
		rd_mux = '0;
		unique case (idx)
			cctt_pkg::IDX_CNT: rd_mux[15:0] = st_r.main_up_counter;
			cctt_pkg::IDX_GRA: rd_mux[15:0] = st_r.gr[0];
			cctt_pkg::IDX_GRB: rd_mux[15:0] = st_r.gr[1];
			cctt_pkg::IDX_GRC: rd_mux[15:0] = st_r.gr[2];
			cctt_pkg::IDX_GRD: rd_mux[15:0] = st_r.gr[3];
			cctt_pkg::IDX_MODE: rd_mux[2:0] = st_r.mode;
			cctt_pkg::IDX_TCTL: rd_mux[7:0] = st_r.timer_control_reg;
			cctt_pkg::IDX_IOC_LO: rd_mux[7:0] = st_r.io_control_low;
			cctt_pkg::IDX_IOC_HI: rd_mux[7:0] = st_r.io_control_high;
			cctt_pkg::IDX_STATUS: rd_mux[4:0] = st_r.flags;
			cctt_pkg::IDX_IEN: rd_mux[4:0] = st_r.ien;
			default: rd_mux = '0;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.presc = st_r.presc + 8'h01;
		st_nxt.src_prev = src_lvl;
		st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
		if (st_nxt.ack) begin
			st_nxt.dat = rd_mux;
		end

		// a read arms exactly the flags software saw as one
		if (acc && !wb_we_i && idx == cctt_pkg::IDX_STATUS) begin
			st_nxt.armed = st_r.armed | st_r.dat[4:0];
		end

		if (wr) begin
			unique case (idx)
				cctt_pkg::IDX_GRA: st_nxt.gr[0] = merge16(st_r.gr[0], wb_dat_i, wb_sel_i);
				cctt_pkg::IDX_GRB: st_nxt.gr[1] = merge16(st_r.gr[1], wb_dat_i, wb_sel_i);
				cctt_pkg::IDX_GRC: st_nxt.gr[2] = merge16(st_r.gr[2], wb_dat_i, wb_sel_i);
				cctt_pkg::IDX_GRD: st_nxt.gr[3] = merge16(st_r.gr[3], wb_dat_i, wb_sel_i);
				cctt_pkg::IDX_MODE: st_nxt.mode = wb_sel_i[0] ? wb_dat_i[2:0] : st_r.mode;
				cctt_pkg::IDX_TCTL: begin
					st_nxt.timer_control_reg = merge8(st_r.timer_control_reg, wb_dat_i, wb_sel_i);
					// pins take the initial levels at once
					st_nxt.pin = st_nxt.timer_control_reg[cctt_pkg::TCTL_INIT_LSB +: cctt_pkg::NCH];
				end
				cctt_pkg::IDX_IOC_LO: st_nxt.io_control_low = merge8(st_r.io_control_low, wb_dat_i, wb_sel_i);
				cctt_pkg::IDX_IOC_HI: st_nxt.io_control_high = merge8(st_r.io_control_high, wb_dat_i, wb_sel_i);
				cctt_pkg::IDX_STATUS: begin
					if (wb_sel_i[0]) begin
						st_nxt.flags = st_r.flags & (wb_dat_i[4:0] | ~st_r.armed);
					end
					st_nxt.armed = '0;
				end
				cctt_pkg::IDX_IEN: st_nxt.ien = wb_sel_i[0] ? wb_dat_i[4:0] : st_r.ien;
				default: st_nxt.armed = st_r.armed;
			endcase
		end

		// clear beats write, write beats count-up
		if (clr_ev) begin
			st_nxt.main_up_counter = '0;
		end else if (cnt_wr) begin
			st_nxt.main_up_counter = merge16(st_r.main_up_counter, wb_dat_i, wb_sel_i);
		end else if (tick) begin
			st_nxt.main_up_counter = st_r.main_up_counter + 16'h0001;
			if (st_r.main_up_counter == cctt_pkg::CNT_MAX) begin
				st_nxt.flags[cctt_pkg::ST_OVF] = 1'b1;
			end
		end

		// hardware events come last so a set wins over a clear
		for (int i = 0; i < cctt_pkg::NCH; i++) begin
			if (match_ev[i]) begin
				st_nxt.flags[i] = 1'b1;
				if (!tctl_wr) begin
					// a control write in the same cycle suppresses this
					unique case (cfg[i][1:0])
						cctt_pkg::OUT_LOW: st_nxt.pin[i] = 1'b0;
						cctt_pkg::OUT_HIGH: st_nxt.pin[i] = 1'b1;
						cctt_pkg::OUT_TOGGLE: st_nxt.pin[i] = ~st_r.pin[i];
						cctt_pkg::OUT_NONE: st_nxt.pin[i] = st_nxt.pin[i];
					endcase
				end
			end
			if (cap_ev[i]) begin
				st_nxt.flags[i] = 1'b1;
				st_nxt.gr[i] = st_r.main_up_counter;
			end
			st_nxt.oe[i] = !cfg[i][cctt_pkg::IOC_CAP] && cfg[i][1:0] != cctt_pkg::OUT_NONE && !idle_ch[i];
		end

		for (int i = 0; i < 2; i++) begin
			if (st_r.mode[cctt_pkg::MODE_BUFA + i]) begin
				if (cap_ev[i]) begin
					st_nxt.gr[i+2] = st_r.gr[i];
				end
				if (match_ev[i]) begin
					st_nxt.gr[i] = st_r.gr[i+2];
				end
			end
		end

		st_nxt.irq = |(st_nxt.flags & st_nxt.ien);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.gr <= {cctt_pkg::NCH{cctt_pkg::GR_RESET}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wb_dat_o = st_r.dat;
	assign wb_ack_o = st_r.ack;
	assign chan_pin_o = st_r.pin;
	assign chan_pin_oe_o = st_r.oe;
	assign irq_o = st_r.irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_match_flag;
		match_ev[1] |=> st_r.flags[1];
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("compare match did not set flag");
	property p_match_moves;
		(match_ev[1] && !cnt_wr && !clr_ev) |=> st_r.main_up_counter == $past(st_r.main_up_counter) + 16'h0001;
	endproperty
	a_match_moves: assert property (p_match_moves) else $error("match raised without counter moving off");
	property p_period_clear;
		(match_ev[0] && st_r.timer_control_reg[cctt_pkg::TCTL_CLEAR_ON_MATCH_ENABLE]) |=> st_r.main_up_counter == 16'h0000;
	endproperty
	a_period_clear: assert property (p_period_clear) else $error("counter not cleared on match a");
	property p_write_wins_count;
		(cnt_wr && !clr_ev && wb_sel_i[1:0] == 2'h3) |=> st_r.main_up_counter == $past(wb_dat_i[15:0]);
	endproperty
	a_write_wins_count: assert property (p_write_wins_count) else $error("counter write lost");
	property p_clear_wins_write;
		(cnt_wr && clr_ev) |=> st_r.main_up_counter == 16'h0000;
	endproperty
	a_clear_wins_write: assert property (p_clear_wins_write) else $error("write beat counter clear");
	property p_overflow;
		(tick && !cnt_wr && !clr_ev && st_r.main_up_counter == cctt_pkg::CNT_MAX) |=> st_r.flags[cctt_pkg::ST_OVF];
	endproperty
	a_overflow: assert property (p_overflow) else $error("wrap did not set overflow");
	property p_pin_high;
		(match_ev[1] && cfg[1][1:0] == cctt_pkg::OUT_HIGH && !tctl_wr) |=> chan_pin_o[1];
	endproperty
	a_pin_high: assert property (p_pin_high) else $error("match did not drive pin high");
	property p_tctl_wins;
		(tctl_wr && wb_sel_i[0]) |=> chan_pin_o == $past(wb_dat_i[7:4]);
	endproperty
	a_tctl_wins: assert property (p_tctl_wins) else $error("pins not loaded from control write");
	property p_capture;
		cap_ev[1] |=> (st_r.gr[1] == $past(st_r.main_up_counter)) && st_r.flags[1];
	endproperty
	a_capture: assert property (p_capture) else $error("capture did not store count and flag");
	property p_buf_capture;
		(cap_ev[0] && st_r.mode[cctt_pkg::MODE_BUFA]) |=> st_r.gr[2] == $past(st_r.gr[0]);
	endproperty
	a_buf_capture: assert property (p_buf_capture) else $error("buffered capture did not shift a into c");
	property p_buf_compare;
		(match_ev[0] && st_r.mode[cctt_pkg::MODE_BUFA]) |=> st_r.gr[0] == $past(st_r.gr[2]);
	endproperty
	a_buf_compare: assert property (p_buf_compare) else $error("buffered compare did not reload a");
	property p_flag_clear;
		(st_wr && wb_sel_i[0] && !wb_dat_i[1] && !match_ev[1] && !cap_ev[1])
			|=> st_r.flags[1] == ($past(st_r.flags[1]) && !$past(st_r.armed[1]));
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag clear not gated by prior read");
	c_match: cover property (match_ev[0] ##1 st_r.flags[0]);
	c_capture: cover property (cap_ev[0]);
	c_overflow: cover property ($rose(st_r.flags[cctt_pkg::ST_OVF]));
	c_clear: cover property ($fell(st_r.flags[0]));

endmodule

`default_nettype wire

/* File: verification/cctt_pin_model.sv */
// far-side model: external count clock and channel pin drivers
`timescale 1ns/1ps
`default_nettype none

module cctt_pin_model (
	input wire logic clk_i,
	input wire logic [3:0] pin_o_i,
	input wire logic [3:0] pin_oe_i,
	output logic ext_clk_o,
	output logic [3:0] pin_lvl_o
);
	logic [3:0] drv_r;

	initial begin
		ext_clk_o = 1'b0;
		drv_r = 4'h0;
	end

	// wire level: the timer wins while it drives, else our driver
	assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drv_r);

	// -----------------------------
	// stimulus tasks
	// -----------------------------
	// high held three cycles, low four between pulses, clock idles low between bursts
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge clk_i);
			ext_clk_o <= 1'b1;
			repeat (3) @(posedge clk_i);
			ext_clk_o <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask

	// new level stands well past the two-cycle minimum and the sampler delay
	task automatic set_pin(input int ch, input logic v);
		@(posedge clk_i);
		drv_r[ch] <= v;
		repeat (6) @(posedge clk_i);
	endtask
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic ext_clk;
	logic [3:0] pin_lvl;
	logic [3:0] chan_pin_o;
	logic [3:0] chan_pin_oe_o;
	logic irq_o;
	int num_errors = 0;
	int compares = 0;
	logic init;

	always #2.5 clk_i = ~clk_i;

	cctt_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk), .chan_pin_i(pin_lvl),
		.chan_pin_o(chan_pin_o), .chan_pin_oe_o(chan_pin_oe_o), .irq_o(irq_o));

	cctt_pin_model i_model (.clk_i(clk_i), .pin_o_i(chan_pin_o), .pin_oe_i(chan_pin_oe_o),
		.ext_clk_o(ext_clk), .pin_lvl_o(pin_lvl));

	// -----------------------------
	// bus and compare tasks
	// -----------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// 16-bit registers take two lanes, the 8-bit ones only lane 0
	task automatic xfer(input logic we, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= (idx <= cctt_pkg::IDX_GRD) ? 4'h3 : 4'h1;
		wb_dat_i <= wd;
		@(posedge clk_i);
		// only the watchdog ends a hung wait
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk_i);
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		xfer(1'b1, idx, wd, d);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] d;
		xfer(1'b0, idx, 32'h0, d);
		check(what, exp, d);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		report_and_stop();
	end

	// -----------------------------
	// tests
	// -----------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(cctt_pkg::IDX_CNT, 32'h0, "counter reset");
		rd(cctt_pkg::IDX_GRA, 32'hffff, "reg a reset");
		rd(cctt_pkg::IDX_GRD, 32'hffff, "reg d reset");
		rd(cctt_pkg::IDX_STATUS, 32'h0, "status reset");
		wr(6'h2f, 32'h5a);
		rd(6'h2f, 32'h0, "unmapped");
		$display("test reset done");

		// periodic compare on channel a, low, high and toggle actions once each
		for (int act = 1; act < 4; act++) begin
			init = (act == 1);
			wr(cctt_pkg::IDX_MODE, 32'h0);
			wr(cctt_pkg::IDX_CNT, 32'h0);
			wr(cctt_pkg::IDX_GRA, 32'h5);
			wr(cctt_pkg::IDX_IOC_LO, 32'(act));
			wr(cctt_pkg::IDX_TCTL, {27'h0, init, 4'hc});
			// pins change at the edge that ends the write; look one edge later
			@(posedge clk_i);
			check("pin a initial", {31'h0, init}, {31'h0, chan_pin_o[0]});
			check("pin a enable", 32'h1, {31'h0, chan_pin_oe_o[0]});
			wr(cctt_pkg::IDX_MODE, 32'h1);
			i_model.ext_pulses(5);
			rd(cctt_pkg::IDX_CNT, 32'h5, "counter at match");
			rd(cctt_pkg::IDX_STATUS, 32'h0, "no early match");
			check("pin a before match", {31'h0, init}, {31'h0, chan_pin_o[0]});
			i_model.ext_pulses(1);
			rd(cctt_pkg::IDX_CNT, 32'h0, "counter cleared");
			check("pin a after match", {31'h0, ~init}, {31'h0, chan_pin_o[0]});
			rd(cctt_pkg::IDX_STATUS, 32'h1, "match flag a");
			wr(cctt_pkg::IDX_STATUS, 32'h0);
			rd(cctt_pkg::IDX_STATUS, 32'h0, "flag cleared");
		end
		$display("test compare done");

		// no clear without the enable; a blind write of zero keeps the flag
		wr(cctt_pkg::IDX_MODE, 32'h0);
		wr(cctt_pkg::IDX_TCTL, 32'h4);
		wr(cctt_pkg::IDX_MODE, 32'h1);
		i_model.ext_pulses(6);
		rd(cctt_pkg::IDX_CNT, 32'h6, "counter runs past a");
		wr(cctt_pkg::IDX_STATUS, 32'h0);
		rd(cctt_pkg::IDX_STATUS, 32'h1, "flag kept");
		wr(cctt_pkg::IDX_STATUS, 32'h0);
		rd(cctt_pkg::IDX_STATUS, 32'h0, "flag cleared");
		$display("test clear enable done");

		// capture on channel b: rise, fall, both, counter held still
		wr(cctt_pkg::IDX_MODE, 32'h0);
		for (int e = 0; e < 3; e++) begin
			wr(cctt_pkg::IDX_IOC_LO, 32'h80 | (32'(e) << 4));
			wr(cctt_pkg::IDX_CNT, 32'h1230 + 32'(e));
			i_model.set_pin(1, 1'b1);
			rd(cctt_pkg::IDX_STATUS, 32'(e != 1) << 1, "capture on rise");
			wr(cctt_pkg::IDX_STATUS, 32'h0);
			i_model.set_pin(1, 1'b0);
			rd(cctt_pkg::IDX_STATUS, 32'(e != 0) << 1, "capture on fall");
			wr(cctt_pkg::IDX_STATUS, 32'h0);
			rd(cctt_pkg::IDX_GRB, 32'h1230 + 32'(e), "captured count");
		end
		$display("test capture done");

		// buffered capture on channel a
		wr(cctt_pkg::IDX_MODE, 32'h2);
		wr(cctt_pkg::IDX_IOC_LO, 32'h08);
		wr(cctt_pkg::IDX_GRA, 32'h1111);
		wr(cctt_pkg::IDX_CNT, 32'h2222);
		i_model.set_pin(0, 1'b1);
		rd(cctt_pkg::IDX_GRA, 32'h2222, "reg a captured");
		rd(cctt_pkg::IDX_GRC, 32'h1111, "reg c buffered");
		rd(cctt_pkg::IDX_STATUS, 32'h1, "capture flag a");
		wr(cctt_pkg::IDX_STATUS, 32'h0);
		$display("test buffer done");

		// overflow with interrupt enabled; c and d kept off compare
		wr(cctt_pkg::IDX_MODE, 32'h0);
		wr(cctt_pkg::IDX_IOC_HI, 32'h88);
		wr(cctt_pkg::IDX_CNT, 32'hffff);
		wr(cctt_pkg::IDX_IEN, 32'h10);
		wr(cctt_pkg::IDX_MODE, 32'h1);
		i_model.ext_pulses(1);
		rd(cctt_pkg::IDX_CNT, 32'h0, "counter wrap");
		rd(cctt_pkg::IDX_STATUS, 32'h10, "overflow flag");
		check("irq raised", 32'h1, {31'h0, irq_o});
		wr(cctt_pkg::IDX_STATUS, 32'h0);
		@(posedge clk_i);
		check("irq cleared", 32'h0, {31'h0, irq_o});
		$display("test overflow done");

		// contention: clear beats a counter write, a counter write beats the count-up
		wr(cctt_pkg::IDX_IEN, 32'h0);
		wr(cctt_pkg::IDX_MODE, 32'h0);
		wr(cctt_pkg::IDX_IOC_LO, 32'h0);
		wr(cctt_pkg::IDX_GRA, 32'h0);
		wr(cctt_pkg::IDX_TCTL, 32'h8);
		wr(cctt_pkg::IDX_MODE, 32'h1);
		wr(cctt_pkg::IDX_CNT, 32'h1234);
		rd(cctt_pkg::IDX_CNT, 32'h0, "clear beats write");
		wr(cctt_pkg::IDX_MODE, 32'h0);
		wr(cctt_pkg::IDX_TCTL, 32'h0);
		wr(cctt_pkg::IDX_MODE, 32'h1);
		wr(cctt_pkg::IDX_CNT, 32'h4000);
		// one system-clock tick passes between the write landing and the read snapshot
		rd(cctt_pkg::IDX_CNT, 32'h4001, "write beats count-up");
		wr(cctt_pkg::IDX_MODE, 32'h0);
		$display("test contention done");
		report_and_stop();
	end
endmodule

`default_nettype wire
